// [hw/spc_regs.vh]
// Register map, field positions and frame constants for the serial config register bank
// Operation
// - Serial config bit 15 picks order: 0 most significant first, 1 least first.
// - Serial config bit 14 picks four wires at 0, one shared data line at 1.
// - Bit 13 set resets port and controllers; all registers but address zero reload.
// - Bit 12 set gives two bidirectional data lines sharing select and clock.
// - Bit 11 doubles the drive strength on the serial output.
// - Bit 10 hands the shared output pin to the auxiliary digital output.
// - Power register bits 11, 10, 9 are read-only regulator on flags.
// - Power bits 8, 7, 6 switch off clock, first and second digital regulators.
// - Power bit 5 disconnects the internal reference pin resistor.
// - Power bit 4 powers down the main bandgap and converter bias.
// - Power bit 3 turns off the converter output current.
// - Clock bit 11 stops the analog clock delivered to the converter.
// - Clock bit 7 gates off the core digital logic clock.
// - Clock bit 6 selects the very low power clocking mode.
// - Clock bit 5 powers down the main clock receiver, stopping all clocks.
// - Clock bit 4 selects the low power receiver, only rising edge stays clean.
// - Clock bit 3 inverts the converter core clock, half period shift, while bit 4 is clear.
// - The serial config register sits at address zero.
`ifndef SPC_REGS_VH
`define SPC_REGS_VH

`define SPC_REG_W          16
`define SPC_ADDR_W         15
`define SPC_ADDR_SERIAL    15'h0000
`define SPC_ADDR_POWER     15'h0001
`define SPC_ADDR_CLOCK     15'h0002
`define SPC_RST_SERIAL     16'h0000
`define SPC_RST_POWER      16'h0000
`define SPC_RST_CLOCK      16'h0000
`define SPC_READ_ZERO      16'h0000

// Serial config fields
`define SPC_SP_BIT_ORDER   15
`define SPC_SP_SHARED_LINE 14
`define SPC_SP_SOFT_RESET  13
`define SPC_SP_DUAL_LINE   12
`define SPC_SP_DRIVE_DBL   11
`define SPC_SP_AUX_PIN     10
`define SPC_SP_RESET_COPY  2

// Power control and status fields
`define SPC_PW_CLKREG_ON   11
`define SPC_PW_DIGA_ON     10
`define SPC_PW_DIGB_ON     9
`define SPC_PW_CLKREG_OFF  8
`define SPC_PW_DIGA_OFF    7
`define SPC_PW_DIGB_OFF    6
`define SPC_PW_REF_RES_OFF 5
`define SPC_PW_BANDGAP_PD  4
`define SPC_PW_CONV_SLEEP  3
`define SPC_PW_STATUS_MASK 16'h0e00

// Clock control fields
`define SPC_CK_CONV_GATE   11
`define SPC_CK_CORE_GATE   7
`define SPC_CK_LOW_POWER   6
`define SPC_CK_RX_PD       5
`define SPC_CK_POWER_SAVE  4
`define SPC_CK_INVERT      3

// Frame layout: 16-bit command (read flag, address) then 16 data bits
`define SPC_CMD_READ       15
`define SPC_CMD_LAST       6'h0f
`define SPC_FRAME_LAST     6'h1f
`define SPC_FRAME_DONE     6'h20
`define SPC_DATA_FIRST     6'h10

// Synchroniser reset levels for {status[2:0], shared, sdio, sclk, cs_n}
`define SPC_SYNC_W         7
`define SPC_SYNC_INIT      7'h01

`endif

// [hw/spc_sync.v]
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module spc_sync #(
  parameter                 WIDTH = 1,
  parameter [WIDTH-1:0]     INIT  = {WIDTH{1'b0}}
) (
  // Clock and reset
  input  wire               clk_sys,
  input  wire               rst_n,
  // Asynchronous inputs and filtered levels
  input  wire [WIDTH-1:0]   din,
  output reg  [WIDTH-1:0]   dout
);

  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;
  reg [WIDTH-1:0] stage3;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      // Stage one feeds only stage two; a new level counts once two and three agree
      always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          stage1[i] <= INIT[i];
          stage2[i] <= INIT[i];
          stage3[i] <= INIT[i];
          dout[i]   <= INIT[i];
        end else begin
          stage1[i] <= din[i];
          stage2[i] <= stage1[i];
          stage3[i] <= stage2[i];
          if (stage2[i] == stage3[i]) begin
            dout[i] <= stage3[i];
          end
        end
      end
    end
  endgenerate

endmodule // spc_sync
`default_nettype wire

// [hw/spc_pin_drive.v]
// Registered drivers for the shared data line and the shared output pin
`timescale 1ns/100ps
`default_nettype none
module spc_pin_drive (
  // Clock and reset
  input  wire clk_sys,
  input  wire rst_n,
  // Serial engine side
  input  wire drive_bit,
  input  wire drive_en,
  input  wire shared_line_select,
  input  wire aux_pin_select,
  input  wire output_drive_double,
  input  wire aux_level,
  // Pins
  output reg  sdio_out,
  output reg  sdio_oe,
  output reg  shared_out,
  output reg  shared_oe,
  output reg  pin_drive_double
);

  // Read data goes to the shared data line in three-wire mode, else to the output pin unless the auxiliary output owns it
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sdio_out         <= 1'b0;
      sdio_oe          <= 1'b0;
      shared_out       <= 1'b0;
      shared_oe        <= 1'b0;
      pin_drive_double <= 1'b0;
    end else begin
      sdio_out         <= drive_bit;
      sdio_oe          <= drive_en & shared_line_select;
      pin_drive_double <= output_drive_double;
      if (aux_pin_select) begin
        // Auxiliary output owns the pin continuously; read data then leaves only on sdio, and only in three-wire mode
        shared_out <= aux_level;
        shared_oe  <= 1'b1;
      end else begin
        shared_out <= drive_bit;
        shared_oe  <= drive_en & ~shared_line_select;
      end
    end
  end

endmodule // spc_pin_drive
`default_nettype wire

// [hw/spc_config_regs.v]
// Serial-port, power and clock configuration registers behind the serial control port
`timescale 1ns/100ps
`default_nettype none
`include "spc_regs.vh"
module spc_config_regs (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        rst_n,
  // Serial control port pins
  input  wire        cs_n,
  input  wire        sclk,
  input  wire        sdio_in,
  output wire        sdio_out,
  output wire        sdio_oe,
  input  wire        shared_in,
  output wire        shared_out,
  output wire        shared_oe,
  output wire        pin_drive_double,
  // Auxiliary digital output level, same clock
  input  wire        aux_level,
  // Regulator status from the analog side
  input  wire        clock_regulator_on,
  input  wire        digital_regulator_a_on,
  input  wire        digital_regulator_b_on,
  // Serial port controls
  output reg         bit_order_select,
  output reg         shared_line_select,
  output reg         dual_data_line_mode,
  output reg         aux_pin_select,
  output reg         soft_reset_pulse,
  // Power controls
  output reg         clock_regulator_off,
  output reg         digital_regulator_a_off,
  output reg         digital_regulator_b_off,
  output reg         reference_resistor_off,
  output reg         bandgap_power_down,
  output reg         converter_sleep,
  // Clock controls
  output reg         converter_clock_gate,
  output reg         core_logic_clock_gate,
  output reg         clock_low_power,
  output reg         clock_receiver_power_down,
  output reg         receiver_power_save,
  output reg         converter_clock_invert
);

  // Register contents
  reg  [`SPC_REG_W-1:0]  serial_port_config;
  reg  [`SPC_REG_W-1:0]  power_control_status;
  reg  [`SPC_REG_W-1:0]  clock_control;

  // Serial engine state
  reg  [5:0]             bit_cnt;
  reg  [`SPC_REG_W-1:0]  rx_shift;
  reg  [`SPC_REG_W-1:0]  tx_shift;
  reg                    cmd_read;
  reg  [`SPC_ADDR_W-1:0] cmd_addr;
  reg                    drive_bit;
  reg                    drive_en;
  reg                    sclk_prev;
  reg                    frame_hold;

  // Filtered pin levels
  wire [`SPC_SYNC_W-1:0] sync_q;
  wire                   cs_n_s;
  wire                   sclk_s;
  wire                   sdio_s;
  wire [2:0]             status_s;

  wire                   sclk_rise;
  wire                   sclk_fall;
  reg  [`SPC_REG_W-1:0]  next_rx;
  reg  [`SPC_REG_W-1:0]  read_word;
  reg  [`SPC_REG_W-1:0]  status_bits;
  // Frame events
  wire                   write_commit;
  wire                   read_launch;

  // All pins and analog flags come from outside the clock domain
  spc_sync #(
    .WIDTH (`SPC_SYNC_W),
    .INIT  (`SPC_SYNC_INIT)
  ) u_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .din     ({clock_regulator_on, digital_regulator_a_on, digital_regulator_b_on,
                shared_in, sdio_in, sclk, cs_n}),
    .dout    (sync_q)
  );

  assign cs_n_s   = sync_q[0];
  assign sclk_s   = sync_q[1];
  assign sdio_s   = sync_q[2];
  assign status_s = sync_q[6:4];

  // Edges of the filtered serial clock; sampling on rise, launching on fall
  assign sclk_rise = ~cs_n_s & sclk_s & ~sclk_prev;
  assign sclk_fall = ~cs_n_s & ~sclk_s & sclk_prev;

  // A write lands on the last sampled rising edge of a write frame, never on a read
  assign write_commit = sclk_rise & (bit_cnt == `SPC_FRAME_LAST) & ~cmd_read;

  // Read bits leave on falling edges from the end of the command to the frame end
  assign read_launch  = sclk_fall & cmd_read & (bit_cnt >= `SPC_DATA_FIRST) &
                        (bit_cnt != `SPC_FRAME_DONE);

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sclk_prev <= 1'b0;
    end else begin
      sclk_prev <= sclk_s;
    end
  end

  // Incoming bit lands at the top or bottom depending on transfer order
  always @* begin
    if (serial_port_config[`SPC_SP_BIT_ORDER]) begin
      next_rx = {sdio_s, rx_shift[`SPC_REG_W-1:1]};
    end else begin
      next_rx = {rx_shift[`SPC_REG_W-2:0], sdio_s};
    end
  end

  // Status flags are live inputs, never stored
  always @* begin
    status_bits = `SPC_READ_ZERO;
    status_bits[`SPC_PW_CLKREG_ON] = status_s[2];
    status_bits[`SPC_PW_DIGA_ON]   = status_s[1];
    status_bits[`SPC_PW_DIGB_ON]   = status_s[0];
  end

  // Read decode; unmapped addresses return zero
  always @* begin
    case (next_rx[`SPC_ADDR_W-1:0])
      `SPC_ADDR_SERIAL: read_word = serial_port_config;
      `SPC_ADDR_POWER:  read_word = power_control_status | status_bits;
      `SPC_ADDR_CLOCK:  read_word = clock_control;
      default:          read_word = `SPC_READ_ZERO;
    endcase
  end

  // Frame engine: 16 command bits, then 16 data bits in either direction
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt    <= 6'h00;
      rx_shift   <= `SPC_READ_ZERO;
      tx_shift   <= `SPC_READ_ZERO;
      cmd_read   <= 1'b0;
      cmd_addr   <= `SPC_ADDR_SERIAL;
      drive_bit  <= 1'b0;
      drive_en   <= 1'b0;
      frame_hold <= 1'b0;
    end else if (cs_n_s) begin
      // Deselect returns the port to idle and ends any hold
      bit_cnt    <= 6'h00;
      drive_en   <= 1'b0;
      cmd_read   <= 1'b0;
      frame_hold <= 1'b0;
    end else if (soft_reset_pulse || frame_hold) begin
      // Soft reset clears the engine; the rest of the frame is ignored until deselect,
      // so stray clocks after the reset cannot start a half-aligned command
      bit_cnt    <= 6'h00;
      rx_shift   <= `SPC_READ_ZERO;
      tx_shift   <= `SPC_READ_ZERO;
      cmd_read   <= 1'b0;
      drive_bit  <= 1'b0;
      drive_en   <= 1'b0;
      frame_hold <= 1'b1;
    end else begin
      // Sample on rises; bits past the end of the frame are ignored
      if (sclk_rise && bit_cnt != `SPC_FRAME_DONE) begin
        rx_shift <= next_rx;
        bit_cnt  <= bit_cnt + 6'h01;
        // Command complete: latch direction and address, fetch the read word
        if (bit_cnt == `SPC_CMD_LAST) begin
          cmd_read <= next_rx[`SPC_CMD_READ];
          cmd_addr <= next_rx[`SPC_ADDR_W-1:0];
          tx_shift <= read_word;
        end
      end
      // Launch read data on falls so it settles before the host's next rise
      if (sclk_fall) begin
        if (read_launch) begin
          drive_en <= 1'b1;
          if (serial_port_config[`SPC_SP_BIT_ORDER]) begin
            drive_bit <= tx_shift[0];
            tx_shift  <= {1'b0, tx_shift[`SPC_REG_W-1:1]};
          end else begin
            drive_bit <= tx_shift[`SPC_REG_W-1];
            tx_shift  <= {tx_shift[`SPC_REG_W-2:0], 1'b0};
          end
        end else begin
          drive_en <= 1'b0;
        end
      end
    end
  end

  // Register writes commit on the last data bit of a write frame
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      serial_port_config   <= `SPC_RST_SERIAL;
      power_control_status <= `SPC_RST_POWER;
      clock_control        <= `SPC_RST_CLOCK;
      soft_reset_pulse     <= 1'b0;
    end else begin
      soft_reset_pulse <= 1'b0;
      if (write_commit) begin
        case (cmd_addr)
          `SPC_ADDR_SERIAL: begin
            // Copy bits are stored as written; the host keeps them mirrored
            serial_port_config <= next_rx;
            if (next_rx[`SPC_SP_SOFT_RESET]) begin
              // Everything but this register reloads; the reset bits self-clear
              serial_port_config[`SPC_SP_SOFT_RESET] <= 1'b0;
              serial_port_config[`SPC_SP_RESET_COPY] <= 1'b0;
              power_control_status <= `SPC_RST_POWER;
              clock_control        <= `SPC_RST_CLOCK;
              soft_reset_pulse     <= 1'b1;
            end
          end
          `SPC_ADDR_POWER: begin
            // Status bits are live inputs and never stored
            power_control_status <= next_rx & ~`SPC_PW_STATUS_MASK;
          end
          `SPC_ADDR_CLOCK: begin
            clock_control <= next_rx;
          end
          default: begin
            // Unmapped address: the write is dropped
            serial_port_config <= serial_port_config;
          end
        endcase
      end
    end
  end

  // Control outputs re-registered so every output leaves a flip-flop
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      // Serial port controls
      bit_order_select          <= 1'b0;
      shared_line_select        <= 1'b0;
      dual_data_line_mode       <= 1'b0;
      aux_pin_select            <= 1'b0;
      // Power controls
      clock_regulator_off       <= 1'b0;
      digital_regulator_a_off   <= 1'b0;
      digital_regulator_b_off   <= 1'b0;
      reference_resistor_off    <= 1'b0;
      bandgap_power_down        <= 1'b0;
      converter_sleep           <= 1'b0;
      // Clock controls
      converter_clock_gate      <= 1'b0;
      core_logic_clock_gate     <= 1'b0;
      clock_low_power           <= 1'b0;
      clock_receiver_power_down <= 1'b0;
      receiver_power_save       <= 1'b0;
      converter_clock_invert    <= 1'b0;
    end else begin
      // Serial port controls
      bit_order_select          <= serial_port_config[`SPC_SP_BIT_ORDER];
      shared_line_select        <= serial_port_config[`SPC_SP_SHARED_LINE];
      dual_data_line_mode       <= serial_port_config[`SPC_SP_DUAL_LINE];
      aux_pin_select            <= serial_port_config[`SPC_SP_AUX_PIN];
      // Power controls
      clock_regulator_off       <= power_control_status[`SPC_PW_CLKREG_OFF];
      digital_regulator_a_off   <= power_control_status[`SPC_PW_DIGA_OFF];
      digital_regulator_b_off   <= power_control_status[`SPC_PW_DIGB_OFF];
      reference_resistor_off    <= power_control_status[`SPC_PW_REF_RES_OFF];
      bandgap_power_down        <= power_control_status[`SPC_PW_BANDGAP_PD];
      converter_sleep           <= power_control_status[`SPC_PW_CONV_SLEEP];
      // Clock controls
      converter_clock_gate      <= clock_control[`SPC_CK_CONV_GATE];
      core_logic_clock_gate     <= clock_control[`SPC_CK_CORE_GATE];
      clock_low_power           <= clock_control[`SPC_CK_LOW_POWER];
      clock_receiver_power_down <= clock_control[`SPC_CK_RX_PD];
      receiver_power_save       <= clock_control[`SPC_CK_POWER_SAVE];
      // Inversion is held off while power save is on: the falling edge is unusable then
      converter_clock_invert    <= clock_control[`SPC_CK_INVERT] &
                                   ~clock_control[`SPC_CK_POWER_SAVE];
    end
  end

  // Pin drivers; the dual-line mode only matters to memory transfers outside this bank
  spc_pin_drive u_pins (
    .clk_sys             (clk_sys),
    .rst_n               (rst_n),
    .drive_bit           (drive_bit),
    .drive_en            (drive_en),
    .shared_line_select  (serial_port_config[`SPC_SP_SHARED_LINE]),
    .aux_pin_select      (serial_port_config[`SPC_SP_AUX_PIN]),
    .output_drive_double (serial_port_config[`SPC_SP_DRIVE_DBL]),
    .aux_level           (aux_level),
    .sdio_out            (sdio_out),
    .sdio_oe             (sdio_oe),
    .shared_out          (shared_out),
    .shared_oe           (shared_oe),
    .pin_drive_double    (pin_drive_double)
  );

endmodule // spc_config_regs
`default_nettype wire

// [test/spc_config_regs_checker.sv]
// Port-level assertions for the configuration register bank
`timescale 1ns/100ps
`default_nettype none
module spc_config_regs_checker (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Serial port and pins
  input wire logic cs_n,
  input wire logic aux_level,
  input wire logic sdio_oe,
  input wire logic shared_oe,
  input wire logic shared_out,
  input wire logic aux_pin_select,
  input wire logic shared_line_select,
  input wire logic soft_reset_pulse,
  // Power and clock controls
  input wire logic bandgap_power_down,
  input wire logic converter_sleep,
  input wire logic converter_clock_gate,
  input wire logic receiver_power_save,
  input wire logic converter_clock_invert
);
  logic [3:0] idle;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  // Cycles since chip select was last low, saturating so it never wraps
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) idle <= 4'hf;
    else if (!cs_n) idle <= 4'h0;
    else if (idle != 4'hf) idle <= idle + 4'h1;
  end

  property p_inv_excl;
    receiver_power_save |-> !converter_clock_invert;
  endproperty
  a_inv_excl: assert property (p_inv_excl) else $error("invert with power save");
  property p_pulse_one;
    soft_reset_pulse |=> !soft_reset_pulse;
  endproperty
  a_pulse_one: assert property (p_pulse_one) else $error("reset pulse too long");
  property p_rst_clr;
    soft_reset_pulse |-> ##[0:2] !(bandgap_power_down | converter_sleep | converter_clock_gate);
  endproperty
  a_rst_clr: assert property (p_rst_clr) else $error("soft reset left controls set");
  property p_rst_frame;
    soft_reset_pulse |-> idle < 4'hc;
  endproperty
  a_rst_frame: assert property (p_rst_frame) else $error("reset pulse outside frame");
  property p_sdio_mode;
    sdio_oe |-> shared_line_select;
  endproperty
  a_sdio_mode: assert property (p_sdio_mode) else $error("data line driven in 4-wire");
  property p_sdio_frame;
    sdio_oe |-> idle < 4'hc;
  endproperty
  a_sdio_frame: assert property (p_sdio_frame) else $error("data line driven idle");
  property p_aux;
    aux_pin_select && $past(aux_pin_select, 2) |-> shared_oe && shared_out == $past(aux_level);
  endproperty
  a_aux: assert property (p_aux) else $error("aux level not on shared pin");
  property p_ctl_frame;
    $changed({bandgap_power_down, converter_sleep, converter_clock_gate}) |-> idle < 4'hc;
  endproperty
  a_ctl_frame: assert property (p_ctl_frame) else $error("control moved outside frame");
endmodule // spc_config_regs_checker

bind spc_config_regs spc_config_regs_checker spc_config_regs_checker_inst (.*);
`default_nettype wire

// [test/spc_host_model.sv]
// Host-side master of the serial control port, mode 0
`timescale 1ns/100ps
`default_nettype none
module spc_host_model (
  // Clock
  input  wire logic clk_sys,
  // Device pins seen by the host
  input  wire logic sdio_out,
  input  wire logic sdio_oe,
  input  wire logic shared_out,
  input  wire logic shared_oe,
  // Host driven pins
  output var  logic cs_n,
  output var  logic sclk,
  output wire logic host_d
);
  logic lsb;   // Bit order in use
  logic three; // Read data on the shared data line
  logic drv;
  logic hbit;
  logic pat;

  // Released line shows a changing pattern, never a stale bit
  assign host_d = drv ? hbit : pat;
  always @(posedge clk_sys) pat <= ~pat;

  initial begin
    {cs_n, sclk, drv, hbit, pat, lsb, three} = 7'h40;
  end

  // One frame on a single data line, as register access needs
  task automatic xfer(input logic rd, input logic [14:0] a, input logic [15:0] wd,
                      input int nb, output logic [15:0] rq);
    logic [15:0] w;
    int          k;
    rq = 16'h0000;
    @(posedge clk_sys);
    cs_n <= 1'b0;
    for (int i = 0; i < nb; i++) begin
      w = (i < 16) ? {rd, a} : wd;
      k = lsb ? i % 16 : 15 - i % 16;
      drv <= !(rd && i >= 16);
      hbit <= w[k];
      repeat (4) @(posedge clk_sys);
      sclk <= 1'b1;
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys);
      if (rd && i >= 16) rq[k] = three ? (sdio_oe ? sdio_out : 1'bx) : (shared_oe ? shared_out : 1'bx);
      @(posedge clk_sys);
      sclk <= 1'b0;
    end
    repeat (4) @(posedge clk_sys);
    cs_n <= 1'b1;
    drv <= 1'b0;
    repeat (8) @(posedge clk_sys);
  endtask
endmodule // spc_host_model
`default_nettype wire

// [test/test_spc_config_regs.sv]
// Self-checking bench for the configuration register bank
`timescale 1ns/100ps
`default_nettype none
module test_spc_config_regs;
  logic clk_sys, rst_n, aux_level, srp_seen;
  logic clock_regulator_on, digital_regulator_a_on, digital_regulator_b_on;
  logic [15:0] q, pw, ck, sp;
  logic [46:0] rows [0:9];
  int   error_cnt = 0;
  int   compares = 0;
  wire  cs_n, sclk, host_d, sdio_out, sdio_oe, shared_out, shared_oe, pin_drive_double;
  wire  bit_order_select, shared_line_select, dual_data_line_mode, aux_pin_select;
  wire  soft_reset_pulse, clock_regulator_off, digital_regulator_a_off, digital_regulator_b_off;
  wire  reference_resistor_off, bandgap_power_down, converter_sleep, converter_clock_gate;
  wire  core_logic_clock_gate, clock_low_power, clock_receiver_power_down;
  wire  receiver_power_save, converter_clock_invert;
  wire  shared_in = 1'b0;
  wire  sdio_in = sdio_oe ? sdio_out : host_d;
  // Control outputs placed at their register bit positions
  wire [15:0] pw_o = {7'h00, clock_regulator_off, digital_regulator_a_off,
                      digital_regulator_b_off, reference_resistor_off, bandgap_power_down,
                      converter_sleep, 3'h0};
  wire [15:0] ck_o = {4'h0, converter_clock_gate, 3'h0, core_logic_clock_gate, clock_low_power,
                      clock_receiver_power_down, receiver_power_save, converter_clock_invert, 3'h0};
  wire [15:0] sp_o = {bit_order_select, shared_line_select, 1'b0, dual_data_line_mode,
                      pin_drive_double, aux_pin_select, 10'h000};

  spc_config_regs spc_config_regs_inst (.*);
  spc_host_model spc_host_model_inst (.*);

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // Sticky record of the one-cycle soft reset pulse
  always @(posedge clk_sys) if (soft_reset_pulse === 1'b1) srp_seen <= 1'b1;

  // Serial config value with its mirrored low bits
  function automatic logic [15:0] mir(input logic [5:0] h);
    mir = {h, 4'h0, h[0], h[1], h[2], h[3], h[4], h[5]};
  endfunction
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [14:0] a, input logic [15:0] d);
    spc_host_model_inst.xfer(1'b0, a, d, 32, q);
  endtask
  task automatic rd(input logic [14:0] a);
    spc_host_model_inst.xfer(1'b1, a, 16'h0000, 32, q);
  endtask
  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (60000) @(posedge clk_sys);
    error_cnt++;
    $display("MISMATCH %0t run timed out", $time);
    test_done();
  end

  initial begin
    {rst_n, aux_level, srp_seen, pw, ck, sp} = 51'h0;
    {clock_regulator_on, digital_regulator_a_on, digital_regulator_b_on} = 3'b101;
    rows[0] = {15'h0001, 16'hffff, 16'hfbff};
    rows[1] = {15'h0001, 16'h0e08, 16'h0a08};
    rows[2] = {15'h0001, 16'h0000, 16'h0a00};
    rows[3] = {15'h0002, 16'hffef, 16'hffef};
    rows[4] = {15'h0002, 16'h0018, 16'h0018};
    rows[5] = {15'h0002, 16'h0810, 16'h0810};
    rows[6] = {15'h0003, 16'h1234, 16'h0000};
    rows[7] = {15'h7fff, 16'hffff, 16'h0000};
    rows[8] = {15'h0000, 16'h0810, 16'h0810};
    rows[9] = {15'h0000, 16'h0000, 16'h0000};
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk_sys);
    // Write, read back, then compare the control outputs
    for (int i = 0; i < 10; i++) begin
      wr(rows[i][46:32], rows[i][31:16]);
      rd(rows[i][46:32]);
      chk(q, rows[i][15:0]);
      if (rows[i][46:32] == 15'h0000) sp = rows[i][15:0];
      if (rows[i][46:32] == 15'h0001) pw = rows[i][15:0];
      if (rows[i][46:32] == 15'h0002) ck = rows[i][15:0];
      chk(pw_o, pw & 16'h01f8);
      chk(ck_o, (ck & 16'h08f0) | {12'h000, ck[3] & ~ck[4], 3'h0});
      chk(sp_o, sp & 16'hdc00);
    end
    $display("test rows done");
    wr(15'h0000, mir(6'b000011));
    aux_level <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk({12'h000, pin_drive_double, aux_pin_select, shared_oe, shared_out}, 16'h000f);
    aux_level <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk({12'h000, pin_drive_double, aux_pin_select, shared_oe, shared_out}, 16'h000e);
    $display("test aux pin done");
    wr(15'h0000, mir(6'b110000));
    spc_host_model_inst.lsb = 1'b1;
    spc_host_model_inst.three = 1'b1;
    wr(15'h0000, mir(6'b110100));
    chk(sp_o, mir(6'b110100) & 16'hdc00);
    wr(15'h0000, mir(6'b110000));
    rd(15'h0000);
    chk(q, mir(6'b110000));
    $display("test wire modes done");
    wr(15'h0001, 16'h01f8);
    wr(15'h0002, 16'h08f0);
    srp_seen <= 1'b0;
    wr(15'h0000, 16'he007);
    chk({15'h0000, srp_seen}, 16'h0001);
    chk(pw_o | ck_o, 16'h0000);
    rd(15'h0001);
    chk(q, 16'h0a00);
    rd(15'h0002);
    chk(q, 16'h0000);
    rd(15'h0000);
    chk(q, 16'hc003);
    $display("test soft reset done");
    {clock_regulator_on, digital_regulator_a_on, digital_regulator_b_on} <= 3'b010;
    spc_host_model_inst.xfer(1'b0, 15'h0001, 16'h0008, 31, q);
    rd(15'h0001);
    chk(q, 16'h0400);
    wr(15'h0000, 16'h0000);
    spc_host_model_inst.lsb = 1'b0;
    spc_host_model_inst.three = 1'b0;
    rd(15'h0000);
    chk(q, 16'h0000);
    $display("test short frame done");
    wr(15'h0002, 16'h0060);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk(pw_o | ck_o | sp_o | {12'h000, sdio_oe, shared_oe, soft_reset_pulse, sdio_out}, 16'h0);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk_sys);
    rd(15'h0002);
    chk(q, 16'h0000);
    $display("test reset done");
    test_done();
  end
endmodule // test_spc_config_regs
`default_nettype wire
